/* logic/acc_pkg.sv */
// Shared constants, types and register map of the converter control block
package acc_pkg;
	localparam logic [5:0] ACC_OFF_SC1 = 6'h00;
	localparam logic [5:0] ACC_OFF_SC2 = 6'h04;
	localparam logic [5:0] ACC_OFF_CFG = 6'h08;
	localparam logic [5:0] ACC_OFF_RES_HIGH = 6'h0c;
	localparam logic [5:0] ACC_OFF_RES_LOW = 6'h10;
	localparam logic [5:0] ACC_OFF_CMP_HIGH = 6'h14;
	localparam logic [5:0] ACC_OFF_CMP_LOW = 6'h18;
	localparam logic [5:0] ACC_OFF_PIN_MID = 6'h1c;
	localparam logic [5:0] ACC_OFF_PIN_HIGH = 6'h20;

	// status_control_one fields
	localparam int ACC_SC1_DONE_BIT = 7;
	localparam int ACC_SC1_IEN_BIT = 6;
	localparam int ACC_SC1_CONT_BIT = 5;
	localparam logic [4:0] ACC_CHAN_DISABLED = 5'h1f;
	localparam logic [4:0] ACC_CHAN_RESET = 5'h1f;
	// status_control_two fields
	localparam int ACC_SC2_ACTIVE_BIT = 7;
	localparam int ACC_SC2_HWT_BIT = 6;
	localparam int ACC_SC2_CMP_EN_BIT = 5;
	localparam int ACC_SC2_CMP_GT_BIT = 4;
	// configuration fields
	localparam int ACC_CFG_DIV_LSB = 5;
	localparam int ACC_CFG_LSMP_BIT = 4;
	localparam int ACC_CFG_MODE_LSB = 2;
	localparam int ACC_CFG_CLK_LSB = 0;

	localparam logic [1:0] ACC_CLK_BUS = 2'h0;
	localparam logic [1:0] ACC_CLK_BUS_HALF = 2'h1;
	localparam logic [1:0] ACC_CLK_ALT = 2'h2;
	localparam logic [1:0] ACC_CLK_ASYNC = 2'h3;

	localparam logic [1:0] ACC_MODE_8 = 2'h0;
	localparam logic [1:0] ACC_MODE_12 = 2'h1;
	localparam logic [1:0] ACC_MODE_10 = 2'h2;

	localparam logic [4:0] ACC_SAMPLE_SHORT = 5'h04;
	localparam logic [4:0] ACC_SAMPLE_LONG = 5'h18;
	localparam logic [3:0] ACC_MSB_INDEX = 4'hb;
	localparam logic [3:0] ACC_LSB_INDEX_12 = 4'h0;
	localparam logic [3:0] ACC_LSB_INDEX_9 = 4'h3;
	localparam logic [7:0] ACC_PIN_RESET = 8'h00;
	localparam int ACC_PINS = 16;

	typedef struct packed {
		logic [1:0] divide;
		logic long_sample;
		logic [1:0] mode;
		logic [1:0] clock_source;
	} acc_cfg_t;
	localparam acc_cfg_t ACC_CFG_RESET = '{2'h0, 1'b0, 2'h0, ACC_CLK_BUS};

	typedef struct packed {
		logic [ACC_PINS-1:0] oe_n;
		logic [ACC_PINS-1:0] drive;
		logic [ACC_PINS-1:0] pullup_en;
		logic [ACC_PINS-1:0] input_en;
		logic [ACC_PINS-1:0] read_data;
	} acc_pads_t;

	typedef enum logic [1:0] {ACC_IDLE, ACC_SAMPLE, ACC_CONVERT, ACC_STORE} acc_state_t;
endpackage

/* logic/acc_conversion_control.sv */
// Converter control: register slave, clock select/divide, SAR sequencing, triggers, pin control
// Functional notes
// - Disabled in reset or channel all ones
// - Idle at lowest power after conversion
// - Raw value 12 bits, or 9 in 8-bit
// - 10-bit mode rounds raw to 10 bits
// - 8-bit mode rounds, writes low result only
// - Set done flag; interrupt when enabled
// - Compare enable turns on automatic compare
// - Four conversion clock sources selectable
// - Reset selects undivided bus clock
// - Halved bus clock with divider reaches 16
// - Async clock keeps running in wait/stop3
// - Divider divides source by 1,2,4,8
// - Mid bits channels 8-15, high 16-23
// - Set bit removes port control of pin
// - Set bit forces output driver off
// - Set bit disables input, port reads zero
// - Set bit switches off the pull-up
// - Hardware trigger rising edge starts conversion
// - Edge ignored while conversion is running
// - Continuous mode honours only first edge
// - Hardware trigger works with every mode
// - Modes 12/10/8; software or hardware start
// - Source codes: bus, half, alternate, async
// - Divide codes 00..11 give 1,2,4,8
// - Mode codes: 00 8, 01 12, 10 10
`timescale 1ns/1ps
module acc_conversion_control
	import acc_pkg::*;
(
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic [5:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic alternate_clock_in,
	input wire logic internal_async_clock_in,
	input wire logic hw_trigger_input_in,
	input wire logic sar_compare_in,
	output logic [11:0] sar_trial_out,
	output logic sar_sample_out,
	output logic [4:0] sar_channel_out,
	output logic converter_enable_out,
	output logic async_clock_enable_out,
	output logic done_irq_out,
	input wire logic [ACC_PINS-1:0] port_data_in,
	input wire logic [ACC_PINS-1:0] port_dir_in,
	input wire logic [ACC_PINS-1:0] port_pullup_in,
	input wire logic [ACC_PINS-1:0] pad_level_in,
	output acc_pads_t pads_out
);
	logic wait_reg;
	logic [31:0] rdata_reg;
	logic [4:0] channel_select_reg;
	logic conversion_done_flag_reg;
	logic done_irq_enable_reg;
	logic continuous_reg;
	logic hw_trigger_enable_reg;
	logic compare_enable_reg;
	logic compare_greater_reg;
	acc_cfg_t cfg_reg;
	logic [7:0] result_high_reg;
	logic [7:0] result_low_reg;
	logic [3:0] cmp_high_reg;
	logic [7:0] cmp_low_reg;
	logic [7:0] analog_pin_ctrl_mid_reg;
	logic [7:0] analog_pin_ctrl_high_reg;
	acc_state_t state_reg;
	logic [11:0] sar_reg;
	logic [3:0] bit_reg;
	logic [4:0] sample_cnt_reg;
	logic half_reg;
	logic [2:0] div_cnt_reg;
	logic [1:0] alt_sync_reg;
	logic alt_last_reg;
	logic [1:0] async_sync_reg;
	logic async_last_reg;
	logic [1:0] trig_sync_reg;
	logic trig_last_reg;
	logic irq_reg;
	acc_pads_t pads_reg;

	logic accept;
	logic wr_accept;
	logic rd_accept;
	logic disabled;
	logic busy;
	logic sw_start;
	logic abort;
	logic hw_start;
	logic src_tick;
	logic [2:0] div_mask;
	logic conversion_clock_tick;
	logic [3:0] lsb_index;
	logic [11:0] raw12;
	logic [11:0] value;
	logic [11:0] cmp_value;
	logic [11:0] diff;
	logic cmp_ok;
	logic store_now;
	logic done_set;
	logic done_clear;
	logic [15:0] pin_sel;

	assign accept = (avs_read_in || avs_write_in) && !wait_reg;
	assign wr_accept = accept && avs_write_in;
	assign rd_accept = accept && avs_read_in;
	assign disabled = (channel_select_reg == ACC_CHAN_DISABLED);
	assign busy = (state_reg != ACC_IDLE);
	// A write with a live channel starts; writes with the hardware trigger armed only abort
	assign sw_start = wr_accept && (avs_address_in == ACC_OFF_SC1)
		&& (avs_writedata_in[4:0] != ACC_CHAN_DISABLED) && !hw_trigger_enable_reg;
	assign abort = wr_accept && (avs_address_in == ACC_OFF_SC1 || avs_address_in == ACC_OFF_SC2
		|| avs_address_in == ACC_OFF_CFG || avs_address_in == ACC_OFF_CMP_HIGH
		|| avs_address_in == ACC_OFF_CMP_LOW);
	// Busy covers continuous runs too, so later edges fall away
	assign hw_start = hw_trigger_enable_reg && trig_sync_reg[1] && !trig_last_reg
		&& !busy && !disabled;

	// Alternate and async sources arrive as slow levels; their rising edges count as ticks
	always_comb begin
		case (cfg_reg.clock_source)
			ACC_CLK_BUS: src_tick = 1'b1;
			ACC_CLK_BUS_HALF: src_tick = half_reg;
			ACC_CLK_ALT: src_tick = alt_sync_reg[1] && !alt_last_reg;
			default: src_tick = async_sync_reg[1] && !async_last_reg;
		endcase
	end

	always_comb begin
		case (cfg_reg.divide)
			2'h0: div_mask = 3'h0;
			2'h1: div_mask = 3'h1;
			2'h2: div_mask = 3'h3;
			default: div_mask = 3'h7;
		endcase
	end
	assign conversion_clock_tick = src_tick && ((div_cnt_reg & div_mask) == div_mask);

	assign lsb_index = (cfg_reg.mode == ACC_MODE_8) ? ACC_LSB_INDEX_9 : ACC_LSB_INDEX_12;

	always_comb begin
		raw12 = sar_reg;
		if (sar_compare_in) begin
			raw12[bit_reg] = 1'b1;
		end
	end

	// Rounding saturates so full scale never wraps to zero
	always_comb begin
		value = raw12;
		if (cfg_reg.mode == ACC_MODE_10) begin
			value = (raw12[11:2] == 10'h3ff) ? 12'h3ff : {2'h0, raw12[11:2] + {9'h0, raw12[1]}};
		end else if (cfg_reg.mode == ACC_MODE_8) begin
			value = (raw12[11:4] == 8'hff) ? 12'h0ff : {4'h0, raw12[11:4] + {7'h0, raw12[3]}};
		end
	end

	always_comb begin
		cmp_value = {cmp_high_reg, cmp_low_reg};
		if (cfg_reg.mode == ACC_MODE_10) begin
			cmp_value = {2'h0, cmp_high_reg[1:0], cmp_low_reg};
		end else if (cfg_reg.mode == ACC_MODE_8) begin
			cmp_value = {4'h0, cmp_low_reg};
		end
	end
	assign diff = value + (~cmp_value + 12'h001);
	assign cmp_ok = !compare_enable_reg
		|| (compare_greater_reg ? (value >= cmp_value) : (value < cmp_value));

	assign store_now = (state_reg == ACC_CONVERT) && conversion_clock_tick && (bit_reg == lsb_index) && !abort;
	assign done_set = store_now && cmp_ok;
	assign done_clear = (wr_accept && avs_address_in == ACC_OFF_SC1)
		|| (rd_accept && avs_address_in == ACC_OFF_RES_LOW);

	// Bus slave: one wait state, data and side effects at the accepting edge
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			wait_reg <= 1'b1;
		end else begin
			wait_reg <= !((avs_read_in || avs_write_in) && wait_reg);
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			rdata_reg <= 32'h0;
		end else if (avs_read_in && wait_reg) begin
			if (avs_address_in == ACC_OFF_SC1) begin
				rdata_reg <= {24'h0, conversion_done_flag_reg, done_irq_enable_reg,
					continuous_reg, channel_select_reg};
			end else if (avs_address_in == ACC_OFF_SC2) begin
				rdata_reg <= {24'h0, busy, hw_trigger_enable_reg, compare_enable_reg,
					compare_greater_reg, 4'h0};
			end else if (avs_address_in == ACC_OFF_CFG) begin
				rdata_reg <= {24'h0, 1'b0, cfg_reg};
			end else if (avs_address_in == ACC_OFF_RES_HIGH) begin
				rdata_reg <= {24'h0, result_high_reg};
			end else if (avs_address_in == ACC_OFF_RES_LOW) begin
				rdata_reg <= {24'h0, result_low_reg};
			end else if (avs_address_in == ACC_OFF_CMP_HIGH) begin
				rdata_reg <= {28'h0, cmp_high_reg};
			end else if (avs_address_in == ACC_OFF_CMP_LOW) begin
				rdata_reg <= {24'h0, cmp_low_reg};
			end else if (avs_address_in == ACC_OFF_PIN_MID) begin
				rdata_reg <= {24'h0, analog_pin_ctrl_mid_reg};
			end else if (avs_address_in == ACC_OFF_PIN_HIGH) begin
				rdata_reg <= {24'h0, analog_pin_ctrl_high_reg};
			end else begin
				rdata_reg <= 32'h0;
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			channel_select_reg <= ACC_CHAN_RESET;
			done_irq_enable_reg <= 1'b0;
			continuous_reg <= 1'b0;
			hw_trigger_enable_reg <= 1'b0;
			compare_enable_reg <= 1'b0;
			compare_greater_reg <= 1'b0;
			cfg_reg <= ACC_CFG_RESET;
			cmp_high_reg <= 4'h0;
			cmp_low_reg <= 8'h00;
			analog_pin_ctrl_mid_reg <= ACC_PIN_RESET;
			analog_pin_ctrl_high_reg <= ACC_PIN_RESET;
		end else if (wr_accept) begin
			if (avs_address_in == ACC_OFF_SC1) begin
				done_irq_enable_reg <= avs_writedata_in[ACC_SC1_IEN_BIT];
				continuous_reg <= avs_writedata_in[ACC_SC1_CONT_BIT];
				channel_select_reg <= avs_writedata_in[4:0];
			end else if (avs_address_in == ACC_OFF_SC2) begin
				hw_trigger_enable_reg <= avs_writedata_in[ACC_SC2_HWT_BIT];
				compare_enable_reg <= avs_writedata_in[ACC_SC2_CMP_EN_BIT];
				compare_greater_reg <= avs_writedata_in[ACC_SC2_CMP_GT_BIT];
			end else if (avs_address_in == ACC_OFF_CFG) begin
				cfg_reg <= acc_cfg_t'(avs_writedata_in[6:0]);
			end else if (avs_address_in == ACC_OFF_CMP_HIGH) begin
				cmp_high_reg <= avs_writedata_in[3:0];
			end else if (avs_address_in == ACC_OFF_CMP_LOW) begin
				cmp_low_reg <= avs_writedata_in[7:0];
			end else if (avs_address_in == ACC_OFF_PIN_MID) begin
				analog_pin_ctrl_mid_reg <= avs_writedata_in[7:0];
			end else if (avs_address_in == ACC_OFF_PIN_HIGH) begin
				analog_pin_ctrl_high_reg <= avs_writedata_in[7:0];
			end
		end
	end

	// Set wins over clear so a result landing on a clearing access is kept
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			conversion_done_flag_reg <= 1'b0;
		end else if (done_set) begin
			conversion_done_flag_reg <= 1'b1;
		end else if (done_clear) begin
			conversion_done_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= (conversion_done_flag_reg || done_set) && done_irq_enable_reg;
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			result_high_reg <= 8'h00;
			result_low_reg <= 8'h00;
		end else if (done_set) begin
			if (cfg_reg.mode == ACC_MODE_8) begin
				result_low_reg <= compare_enable_reg ? diff[7:0] : value[7:0];
			end else begin
				result_high_reg <= {4'h0, compare_enable_reg ? diff[11:8] : value[11:8]};
				result_low_reg <= compare_enable_reg ? diff[7:0] : value[7:0];
			end
		end
	end

	// Source edge detectors; the first stage of each pair feeds only the second
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			alt_sync_reg <= 2'h0;
			alt_last_reg <= 1'b0;
			async_sync_reg <= 2'h0;
			async_last_reg <= 1'b0;
			trig_sync_reg <= 2'h0;
			trig_last_reg <= 1'b0;
		end else begin
			alt_sync_reg <= {alt_sync_reg[0], alternate_clock_in};
			alt_last_reg <= alt_sync_reg[1];
			async_sync_reg <= {async_sync_reg[0], internal_async_clock_in};
			async_last_reg <= async_sync_reg[1];
			trig_sync_reg <= {trig_sync_reg[0], hw_trigger_input_in};
			trig_last_reg <= trig_sync_reg[1];
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in || !busy) begin
			half_reg <= 1'b0;
			div_cnt_reg <= 3'h0;
		end else begin
			half_reg <= !half_reg;
			if (src_tick) begin
				div_cnt_reg <= div_cnt_reg + 3'h1;
			end
		end
	end

	// Sequencer; abort from status, config or compare register writes, restart when continuous or started anew
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			state_reg <= ACC_IDLE;
			sar_reg <= 12'h000;
			bit_reg <= ACC_MSB_INDEX;
			sample_cnt_reg <= 5'h00;
		end else if (sw_start || hw_start) begin
			state_reg <= ACC_SAMPLE;
			sample_cnt_reg <= 5'h00;
		end else if (abort || disabled) begin
			state_reg <= ACC_IDLE;
		end else begin
			case (state_reg)
				ACC_SAMPLE: begin
					sar_reg <= 12'h000;
					bit_reg <= ACC_MSB_INDEX;
					if (conversion_clock_tick) begin
						sample_cnt_reg <= sample_cnt_reg + 5'h01;
						if (sample_cnt_reg + 5'h01 ==
							(cfg_reg.long_sample ? ACC_SAMPLE_LONG : ACC_SAMPLE_SHORT)) begin
							state_reg <= ACC_CONVERT;
						end
					end
				end
				ACC_CONVERT: begin
					if (conversion_clock_tick) begin
						sar_reg <= raw12;
						if (bit_reg == lsb_index) begin
							state_reg <= ACC_STORE;
						end else begin
							bit_reg <= bit_reg - 4'h1;
						end
					end
				end
				ACC_STORE: begin
					sample_cnt_reg <= 5'h00;
					state_reg <= continuous_reg ? ACC_SAMPLE : ACC_IDLE;
				end
				default: state_reg <= ACC_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			sar_trial_out <= 12'h800;
			sar_sample_out <= 1'b0;
			sar_channel_out <= ACC_CHAN_RESET;
			converter_enable_out <= 1'b0;
			async_clock_enable_out <= 1'b0;
		end else begin
			// Trial moves only on a tick so slow conversion clocks keep it steady
			if (state_reg != ACC_CONVERT) begin
				sar_trial_out <= 12'h800;
			end else if (conversion_clock_tick) begin
				sar_trial_out <= raw12 | (12'h001 << (bit_reg - 4'h1));
			end
			sar_sample_out <= (state_reg == ACC_SAMPLE);
			sar_channel_out <= channel_select_reg;
			converter_enable_out <= busy;
			// Held by the converter alone, not by system power modes
			async_clock_enable_out <= busy && (cfg_reg.clock_source == ACC_CLK_ASYNC);
		end
	end

	assign pin_sel = {analog_pin_ctrl_high_reg, analog_pin_ctrl_mid_reg};

	for (genvar i = 0; i < ACC_PINS; i++) begin : g_pin
		always_ff @(posedge clock_in) begin
			if (reset_in) begin
				pads_reg.oe_n[i] <= 1'b1;
				pads_reg.drive[i] <= 1'b0;
				pads_reg.pullup_en[i] <= 1'b0;
				pads_reg.input_en[i] <= 1'b1;
				pads_reg.read_data[i] <= 1'b0;
			end else begin
				pads_reg.oe_n[i] <= pin_sel[i] || !port_dir_in[i];
				pads_reg.drive[i] <= port_data_in[i] && !pin_sel[i];
				pads_reg.pullup_en[i] <= port_pullup_in[i] && !pin_sel[i];
				pads_reg.input_en[i] <= !pin_sel[i];
				pads_reg.read_data[i] <= pad_level_in[i] && !pin_sel[i];
			end
		end
	end

	assign avs_readdata_out = rdata_reg;
	assign avs_waitrequest_out = wait_reg;
	assign done_irq_out = irq_reg;
	assign pads_out = pads_reg;
endmodule

/* tb/acc_conversion_control_monitor.sv */
// Port-level checker for the converter control block
`timescale 1ns/1ps
module acc_ctl_monitor
	import acc_pkg::*;
(
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic [5:0] avs_address_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic avs_waitrequest_out,
	input wire logic [11:0] sar_trial_out,
	input wire logic sar_sample_out,
	input wire logic [4:0] sar_channel_out,
	input wire logic converter_enable_out,
	input wire logic async_clock_enable_out,
	input wire logic done_irq_out,
	input wire acc_pads_t pads_out
);
	logic wr_done;
	logic [15:0] iso_reg;
	logic [15:0] iso_d_reg;
	logic [1:0] src_reg;
	assign wr_done = avs_write_in && !avs_waitrequest_out;
	// Pads lag the pin registers by one cycle, so compare against the delayed copy
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			iso_reg <= 16'h0000;
			iso_d_reg <= 16'h0000;
		end else begin
			iso_d_reg <= iso_reg;
			if (wr_done && avs_address_in == ACC_OFF_PIN_MID) iso_reg[7:0] <= avs_writedata_in[7:0];
			if (wr_done && avs_address_in == ACC_OFF_PIN_HIGH) iso_reg[15:8] <= avs_writedata_in[7:0];
		end
	end
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			src_reg <= ACC_CLK_BUS;
		end else if (wr_done && avs_address_in == ACC_OFF_CFG) begin
			src_reg <= avs_writedata_in[1:0];
		end
	end
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (reset_in);
	off_after_reset_a: assert property ($fell(reset_in) |-> !converter_enable_out [*2])
		else $error("converter active right after reset");
	chan_off_a: assert property (sar_channel_out == ACC_CHAN_DISABLED [*2] |-> !converter_enable_out)
		else $error("converter active with channel disabled");
	idle_quiet_a: assert property (!converter_enable_out [*2] |-> !sar_sample_out && sar_trial_out == 12'h800)
		else $error("sequencer active while idle");
	async_src_a: assert property (async_clock_enable_out |-> src_reg == ACC_CLK_ASYNC && converter_enable_out)
		else $error("async clock enabled without need");
	start_sample_a: assert property ($rose(converter_enable_out) |-> ##[0:1] sar_sample_out)
		else $error("conversion did not begin with sampling");
	pad_hiz_a: assert property ((pads_out.oe_n & iso_d_reg) == iso_d_reg && (pads_out.drive & iso_d_reg) == 16'h0)
		else $error("isolated pad driven");
	pad_input_off_a: assert property (((pads_out.read_data | pads_out.input_en) & iso_d_reg) == 16'h0)
		else $error("isolated pad input active");
	pad_pull_off_a: assert property ((pads_out.pullup_en & iso_d_reg) == 16'h0)
		else $error("isolated pad pull-up on");
	cover property ($rose(done_irq_out));
	cover property (async_clock_enable_out);
	cover property ($rose(converter_enable_out) && src_reg == ACC_CLK_BUS_HALF);
endmodule

/* tb/acc_analog_model.sv */
// Analog front end: track-and-hold input feeding the comparator
`timescale 1ns/1ps
module acc_analog_model (
	input wire logic clock_in,
	input wire logic [11:0] level_in,
	input wire logic [11:0] sar_trial_in,
	input wire logic sar_sample_in,
	input wire logic converter_enable_in,
	output logic sar_compare_out
);
	logic [11:0] held_reg = 12'h000;
	logic noise_reg = 1'b0;
	// Later level changes must not leak into a conversion already past sampling
	always_ff @(posedge clock_in) begin
		if (sar_sample_in) held_reg <= level_in;
	end
	always_ff @(posedge clock_in) begin
		noise_reg <= !noise_reg;
	end
	// A powered-down comparator gives no usable answer
	assign sar_compare_out = converter_enable_in ? (held_reg >= sar_trial_in) : noise_reg;
endmodule

/* tb/acc_conversion_control_tb.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module acc_conversion_control_tb
	import acc_pkg::*;
;
	typedef struct {logic [5:0] a; logic [31:0] v;} acc_note_t;
	logic clock_in = 1'b0;
	logic reset_in = 1'b1;
	logic [5:0] avs_address_in = 6'h00;
	logic avs_read_in = 1'b0;
	logic avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h0;
	logic [31:0] avs_readdata_out;
	logic avs_waitrequest_out;
	logic alternate_clock_in = 1'b0;
	logic internal_async_clock_in = 1'b0;
	logic hw_trigger_input_in = 1'b0;
	logic sar_compare_in;
	logic [11:0] sar_trial_out;
	logic sar_sample_out;
	logic [4:0] sar_channel_out;
	logic converter_enable_out;
	logic async_clock_enable_out;
	logic done_irq_out;
	logic [15:0] port_data_in = 16'h0;
	logic [15:0] port_dir_in = 16'h0;
	logic [15:0] port_pullup_in = 16'hffff;
	logic [15:0] pad_level_in = 16'hffff;
	acc_pads_t pads_out;
	logic [11:0] level = 12'h0;
	int n_mismatch = 0;
	int checks_done = 0;
	acc_note_t notes[$];
	initial forever #20 clock_in = ~clock_in;
	initial #3 forever #75 alternate_clock_in = ~alternate_clock_in;
	initial #3 forever #115 internal_async_clock_in = ~internal_async_clock_in;
	acc_conversion_control uut (.clock_in(clock_in), .reset_in(reset_in),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out), .alternate_clock_in(alternate_clock_in),
		.internal_async_clock_in(internal_async_clock_in), .hw_trigger_input_in(hw_trigger_input_in),
		.sar_compare_in(sar_compare_in), .sar_trial_out(sar_trial_out), .sar_sample_out(sar_sample_out),
		.sar_channel_out(sar_channel_out), .converter_enable_out(converter_enable_out),
		.async_clock_enable_out(async_clock_enable_out), .done_irq_out(done_irq_out),
		.port_data_in(port_data_in), .port_dir_in(port_dir_in), .port_pullup_in(port_pullup_in),
		.pad_level_in(pad_level_in), .pads_out(pads_out));
	acc_analog_model model (.clock_in(clock_in), .level_in(level), .sar_trial_in(sar_trial_out),
		.sar_sample_in(sar_sample_out), .converter_enable_in(converter_enable_out),
		.sar_compare_out(sar_compare_in));
	task automatic conclude();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic cmp_reg(input acc_note_t e, input logic [31:0] s);
		checks_done++;
		if (s !== e.v) begin
			n_mismatch++;
			$display("[FAIL] reg_%h expected %h seen %h", e.a, e.v, s);
		end
	endtask
	always @(posedge clock_in) begin
		if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0) begin
			if (notes.size() == 0) n_mismatch++;
			else cmp_reg(notes.pop_front(), avs_readdata_out);
		end
	end
	task automatic bus(input logic rd, input logic [5:0] a, input logic [7:0] d);
		int n;
		n = 0;
		avs_address_in <= a;
		avs_writedata_in <= {24'h0, d};
		avs_read_in <= rd;
		avs_write_in <= !rd;
		do begin
			@(posedge clock_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0 && n < 100);
		if (avs_waitrequest_out !== 1'b0) begin
			n_mismatch++;
			conclude();
		end
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
		@(posedge clock_in);
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		bus(1'b0, a, d);
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		notes.push_back('{a, e});
		bus(1'b1, a, 8'h00);
	endtask
	task automatic wait_en(input logic v, input int lim, output int n);
		n = 0;
		while (converter_enable_out !== v && n < lim) begin
			@(posedge clock_in);
			n++;
		end
		if (n >= lim) begin
			n_mismatch++;
			conclude();
		end
	endtask
	task automatic pulse();
		hw_trigger_input_in <= 1'b1;
		repeat (3) @(posedge clock_in);
		hw_trigger_input_in <= 1'b0;
		repeat (3) @(posedge clock_in);
	endtask
	task automatic conv(input logic [7:0] cfg, input logic [11:0] lv, input logic dn, output int n);
		level <= lv;
		wr(ACC_OFF_CFG, cfg);
		wr(ACC_OFF_SC1, 8'h45);
		wait_en(1'b1, 40, n);
		wait_en(1'b0, 4000, n);
		repeat (3) @(posedge clock_in);
		cmp("done_irq", {31'h0, dn}, {31'h0, done_irq_out});
	endtask
	function automatic logic [11:0] exp_res(input logic [1:0] md, input logic [11:0] lv);
		logic [12:0] t;
		if (md == ACC_MODE_12) return lv;
		if (md == ACC_MODE_10) begin
			t = ({1'b0, lv} + 13'h2) >> 2;
			return (t > 13'h3ff) ? 12'h3ff : t[11:0];
		end
		t = ({4'h0, lv[11:3]} + 13'h1) >> 1;
		return (t > 13'h0ff) ? 12'h0ff : t[11:0];
	endfunction
	initial begin
		int cyc;
		int k;
		int t;
		logic [11:0] lv;
		logic [11:0] r;
		logic [7:0] m;
		logic [7:0] h;
		logic [1:0] md;
		void'($urandom(14771));
		repeat (6) @(posedge clock_in);
		reset_in <= 1'b0;
		@(posedge clock_in);
		rd(ACC_OFF_SC1, 32'h1f);
		rd(ACC_OFF_CFG, 32'h0);
		rd(ACC_OFF_PIN_MID, 32'h0);
		rd(ACC_OFF_PIN_HIGH, 32'h0);
		rd(6'h3c, 32'h0);
		m = 8'($urandom);
		h = 8'($urandom);
		port_dir_in <= 16'($urandom);
		port_data_in <= 16'($urandom);
		wr(ACC_OFF_PIN_MID, m);
		wr(ACC_OFF_PIN_HIGH, h);
		repeat (2) @(posedge clock_in);
		cmp("pads_off", 32'h0, {16'h0, (pads_out.read_data | pads_out.pullup_en
			| pads_out.input_en | pads_out.drive) & {h, m}});
		cmp("pads_oe_n", {16'h0, ~port_dir_in | {h, m}}, {16'h0, pads_out.oe_n});
		cmp("pads_drive", {16'h0, port_data_in & ~{h, m}}, {16'h0, pads_out.drive});
		cmp("pads_pullup", {16'h0, ~{h, m}}, {16'h0, pads_out.pullup_en});
		rd(ACC_OFF_PIN_HIGH, {24'h0, h});
		for (int s = 0; s < 4; s++) begin
			for (int d = 0; d < 4; d++) begin
				md = 2'((s + d) % 3);
				lv = 12'($urandom);
				conv({1'b0, 2'(d), 1'b0, md, 2'(s)}, lv, 1'b1, cyc);
				k = (s == 1 ? 2 : 1) << d;
				t = 4 + (md == ACC_MODE_8 ? 9 : 12);
				if (s < 2) cmp("conv_cycles", 1, (cyc >= (t - 1) * k && cyc <= (t + 1) * k + 4));
				r = exp_res(md, lv);
				if (md != ACC_MODE_8) rd(ACC_OFF_RES_HIGH, {28'h0, r[11:8]});
				rd(ACC_OFF_RES_LOW, {24'h0, r[7:0]});
			end
		end
		wr(ACC_OFF_SC2, 8'h30);
		wr(ACC_OFF_CMP_HIGH, 8'h01);
		wr(ACC_OFF_CMP_LOW, 8'h23);
		conv({4'h0, ACC_MODE_12, ACC_CLK_BUS}, 12'h456, 1'b1, cyc);
		rd(ACC_OFF_RES_HIGH, 32'h3);
		rd(ACC_OFF_RES_LOW, 32'h33);
		conv({4'h0, ACC_MODE_12, ACC_CLK_BUS}, 12'h100, 1'b0, cyc);
		rd(ACC_OFF_RES_LOW, 32'h33);
		wr(ACC_OFF_SC2, 8'h40);
		wr(ACC_OFF_CFG, {4'h0, ACC_MODE_8, ACC_CLK_BUS});
		lv = 12'($urandom);
		level <= lv;
		wr(ACC_OFF_SC1, 8'h45);
		repeat (4) @(posedge clock_in);
		cmp("sw_start_blocked", 0, converter_enable_out);
		pulse();
		wait_en(1'b1, 20, cyc);
		pulse();
		wait_en(1'b0, 400, cyc);
		cmp("edge_ignored", 1, cyc <= 10);
		repeat (10) @(posedge clock_in);
		cmp("idle_after_edge", 0, converter_enable_out);
		r = exp_res(ACC_MODE_8, lv);
		rd(ACC_OFF_RES_LOW, {24'h0, r[7:0]});
		wr(ACC_OFF_SC1, 8'h65);
		pulse();
		cyc = 0;
		while (done_irq_out !== 1'b1 && cyc < 400) begin
			@(posedge clock_in);
			cyc++;
		end
		cmp("cont_done", 1, done_irq_out);
		cmp("cont_restart", 1, converter_enable_out);
		wr(ACC_OFF_SC1, 8'h1f);
		repeat (4) @(posedge clock_in);
		cmp("disabled", 0, converter_enable_out);
		conclude();
	end
endmodule
bind acc_conversion_control acc_ctl_monitor mon (.clock_in(clock_in), .reset_in(reset_in),
	.avs_address_in(avs_address_in), .avs_write_in(avs_write_in),
	.avs_writedata_in(avs_writedata_in), .avs_waitrequest_out(avs_waitrequest_out),
	.sar_trial_out(sar_trial_out), .sar_sample_out(sar_sample_out),
	.sar_channel_out(sar_channel_out), .converter_enable_out(converter_enable_out),
	.async_clock_enable_out(async_clock_enable_out), .done_irq_out(done_irq_out),
	.pads_out(pads_out));
